// ---- logic/bbce_exec.sv ----
// Decode and execute core for branch, invoke, bit-flip, watchdog, invert and compare
`timescale 1ns/100ps
// Contract
// - Zero-set branch jumps only when zero flag is one; two cycles not taken, three taken.
// - Taken branch target is incremented PC plus twice signed offset.
// - Invoke uses two words; twenty literal bits load PC bits 20 to 1.
// - Invert produces complement of register, updates negative and zero flags.
// - Invert destination bit set sends result to W, clear writes register.
// - Access bit zero selects the access bank, not the bank pointer.
// - Access bit one takes the bank number from the bank pointer.
// - Extended mode, access zero, address up to 95 uses indexed offset.
// - Compare-equal subtracts unsigned, changes no flags, stores nothing.
// - Watchdog service clears counter, sets expiry and power flags.
module bbce_exec (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic ext_mode_i,
   input wire logic [3:0] bank_select_pointer_i,
   input wire logic [11:0] index_base_i,
   input wire logic [7:0] fr_rdata_i,
   output logic instr_ready_o,
   output logic [20:0] pc_o,
   output logic [11:0] fr_addr_o,
   output logic fr_we_o,
   output logic [7:0] fr_wdata_o,
   output logic [7:0] w_o,
   output logic zero_flag_o,
   output logic neg_flag_o,
   output logic watchdog_expiry_flag_o,
   output logic power_down_flag_o,
   output logic watchdog_counter_clear_o,
   output logic stack_push_o,
   output logic [20:0] stack_top_entry_o,
   output logic [7:0] accum_shadow_o,
   output logic [1:0] flags_shadow_o,
   output logic [3:0] bank_pointer_shadow_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   bbce_pkg::bbce_state_t state_q, state_d;
   logic ready_q, ready_d;
   logic [15:0] ir_q, ir_d;
   logic [20:0] pc_q, pc_d;
   logic [11:0] addr_q, addr_d;
   logic we_q, we_d;
   logic [7:0] wdata_q, wdata_d;
   logic [7:0] w_q, w_d;
   logic z_q, z_d, n_q, n_d, to_q, to_d, pd_q, pd_d;
   logic wdc_q, wdc_d;
   logic push_q, push_d;
   logic [20:0] tos_q, tos_d;
   logic [7:0] klo_q, klo_d;
   logic [7:0] ws_q, ws_d;
   logic [1:0] fs_q, fs_d;
   logic [3:0] bs_q, bs_d;
   logic accept;
   logic [11:0] eff_addr;
   logic [20:0] bz_target;
   logic [20:0] call_target;
   logic [7:0] bit_mask;
   logic [7:0] inv_res;
   logic is_bz, is_wds, is_inv, is_flip, is_cmp;
   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   assign accept = instr_valid_i & ready_q;
   assign is_bz = ir_q[15:8] == bbce_pkg::OP_BRANCH_ON_ZERO_SET;
   assign is_wds = ir_q == bbce_pkg::OP_WATCHDOG_SERVICE;
   assign is_inv = ir_q[15:10] == bbce_pkg::OP_INVERT_FILE_BYTE;
   assign is_flip = ir_q[15:12] == bbce_pkg::OP_BIT_FLIP;
   assign is_cmp = ir_q[15:9] == bbce_pkg::OP_COMPARE_EQUAL_SKIP;
   assign bz_target = pc_q + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
   assign call_target = {instr_i[11:0], klo_q, 1'b0};
   assign bit_mask = bbce_pkg::BIT_ONE << ir_q[11:9];
   assign inv_res = ~fr_rdata_i;
   always_comb begin
      eff_addr = {bank_select_pointer_i, instr_i[7:0]};
      if (!instr_i[8]) begin
         if (ext_mode_i && instr_i[7:0] <= bbce_pkg::INDEX_MAX) begin
            eff_addr = index_base_i + {4'h0, instr_i[7:0]};
         end else if (instr_i[7:0] < bbce_pkg::ACCESS_SPLIT) begin
            eff_addr = {bbce_pkg::ACCESS_LOW_BANK, instr_i[7:0]};
         end else begin
            eff_addr = {bbce_pkg::ACCESS_HIGH_BANK, instr_i[7:0]};
         end
      end
   end
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      ir_d = ir_q;
      pc_d = pc_q;
      addr_d = addr_q;
      we_d = 1'b0;
      wdata_d = wdata_q;
      w_d = w_q;
      z_d = z_q;
      n_d = n_q;
      to_d = to_q;
      pd_d = pd_q;
      wdc_d = 1'b0;
      push_d = 1'b0;
      tos_d = tos_q;
      klo_d = klo_q;
      ws_d = ws_q;
      fs_d = fs_q;
      bs_d = bs_q;
      case (state_q)
         bbce_pkg::ST_FETCH: begin
            if (accept) begin
               ir_d = instr_i;
               pc_d = pc_q + bbce_pkg::PC_STEP;
               addr_d = eff_addr;
               if (instr_i[15:9] == bbce_pkg::OP_INVOKE_FIRST) begin
                  klo_d = instr_i[7:0];
                  state_d = bbce_pkg::ST_INVOKE2;
               end else begin
                  state_d = bbce_pkg::ST_EXEC;
               end
            end
         end
         bbce_pkg::ST_EXEC: begin
            state_d = bbce_pkg::ST_FETCH;
            if (is_bz) begin
               if (z_q) begin
                  pc_d = bz_target;
                  state_d = bbce_pkg::ST_NOP;
               end
            end else if (is_wds) begin
               wdc_d = 1'b1;
               to_d = 1'b1;
               pd_d = 1'b1;
            end else if (is_inv) begin
               n_d = inv_res[7];
               z_d = inv_res == bbce_pkg::BYTE_RESET;
               if (ir_q[9]) begin
                  w_d = inv_res;
               end else begin
                  we_d = 1'b1;
                  wdata_d = inv_res;
               end
            end else if (is_flip) begin
               we_d = 1'b1;
               wdata_d = fr_rdata_i ^ bit_mask;
            end else if (is_cmp) begin
               if (fr_rdata_i - w_q == bbce_pkg::BYTE_RESET) begin
                  state_d = bbce_pkg::ST_DROP;
               end
            end
         end
         bbce_pkg::ST_INVOKE2: begin
            if (accept) begin
               if (instr_i[15:12] == bbce_pkg::OP_INVOKE_SECOND) begin
                  pc_d = call_target;
                  push_d = 1'b1;
                  tos_d = pc_q + bbce_pkg::PC_STEP;
                  if (ir_q[8]) begin
                     ws_d = w_q;
                     fs_d = {n_q, z_q};
                     bs_d = bank_select_pointer_i;
                  end
                  state_d = bbce_pkg::ST_NOP;
               end else begin
                  pc_d = pc_q + bbce_pkg::PC_STEP;
                  state_d = bbce_pkg::ST_FETCH;
               end
            end
         end
         bbce_pkg::ST_DROP: begin
            if (accept) begin
               pc_d = pc_q + bbce_pkg::PC_STEP;
               state_d = bbce_pkg::ST_FETCH;
            end
         end
         default: begin
            state_d = bbce_pkg::ST_FETCH;
         end
      endcase
      ready_d = (state_d == bbce_pkg::ST_FETCH) || (state_d == bbce_pkg::ST_INVOKE2) || (state_d == bbce_pkg::ST_DROP);
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= bbce_pkg::ST_FETCH;
         ready_q <= 1'b0;
         ir_q <= bbce_pkg::WORD_RESET;
         pc_q <= bbce_pkg::PC_RESET;
         addr_q <= bbce_pkg::ADDR_RESET;
         we_q <= 1'b0;
         wdata_q <= bbce_pkg::BYTE_RESET;
         w_q <= bbce_pkg::BYTE_RESET;
         z_q <= 1'b0;
         n_q <= 1'b0;
         to_q <= 1'b1;
         pd_q <= 1'b1;
         wdc_q <= 1'b0;
         push_q <= 1'b0;
         tos_q <= bbce_pkg::PC_RESET;
         klo_q <= bbce_pkg::BYTE_RESET;
         ws_q <= bbce_pkg::BYTE_RESET;
         fs_q <= 2'h0;
         bs_q <= 4'h0;
      end else begin
         state_q <= state_d;
         ready_q <= ready_d;
         ir_q <= ir_d;
         pc_q <= pc_d;
         addr_q <= addr_d;
         we_q <= we_d;
         wdata_q <= wdata_d;
         w_q <= w_d;
         z_q <= z_d;
         n_q <= n_d;
         to_q <= to_d;
         pd_q <= pd_d;
         wdc_q <= wdc_d;
         push_q <= push_d;
         tos_q <= tos_d;
         klo_q <= klo_d;
         ws_q <= ws_d;
         fs_q <= fs_d;
         bs_q <= bs_d;
      end
   end
   assign instr_ready_o = ready_q;
   assign pc_o = pc_q;
   assign fr_addr_o = addr_q;
   assign fr_we_o = we_q;
   assign fr_wdata_o = wdata_q;
   assign w_o = w_q;
   assign zero_flag_o = z_q;
   assign neg_flag_o = n_q;
   assign watchdog_expiry_flag_o = to_q;
   assign power_down_flag_o = pd_q;
   assign watchdog_counter_clear_o = wdc_q;
   assign stack_push_o = push_q;
   assign stack_top_entry_o = tos_q;
   assign accum_shadow_o = ws_q;
   assign flags_shadow_o = fs_q;
   assign bank_pointer_shadow_o = bs_q;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic ex;
   assign ex = state_q == bbce_pkg::ST_EXEC;
   AST_BZ_TAKEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_bz && z_q |=> pc_q == $past(pc_q) + {{12{$past(ir_q[7])}}, $past(ir_q[7:0]), 1'b0} &&
      state_q == bbce_pkg::ST_NOP ##1 state_q == bbce_pkg::ST_FETCH) else $error("branch taken path wrong");
   AST_BZ_NOT_TAKEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_bz && !z_q |=> $stable(pc_q) && state_q == bbce_pkg::ST_FETCH) else $error("branch not taken moved pc");
   AST_INVOKE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == bbce_pkg::ST_INVOKE2 && accept && instr_i[15:12] == bbce_pkg::OP_INVOKE_SECOND
      |=> pc_q == $past(call_target) && stack_push_o && stack_top_entry_o == $past(pc_q) + 21'h000002)
      else $error("invoke target or push wrong");
   AST_SHADOW: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == bbce_pkg::ST_INVOKE2 && accept && ir_q[8] && instr_i[15:12] == bbce_pkg::OP_INVOKE_SECOND
      |=> accum_shadow_o == $past(w_q) && bank_pointer_shadow_o == $past(bank_select_pointer_i))
      else $error("shadow copy wrong");
   AST_INVERT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_inv |=> z_q == ($past(fr_rdata_i) == 8'hFF) && n_q == !$past(fr_rdata_i[7]))
      else $error("invert flags wrong");
   AST_INVERT_DEST: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_inv && !ir_q[9] |=> fr_we_o && fr_wdata_o == ~$past(fr_rdata_i) && $stable(w_q))
      else $error("invert writeback wrong");
   AST_BANK_PTR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == bbce_pkg::ST_FETCH && accept && instr_i[8]
      |=> fr_addr_o[11:8] == $past(bank_select_pointer_i)) else $error("bank pointer not used");
   AST_ACCESS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == bbce_pkg::ST_FETCH && accept && !instr_i[8] && !ext_mode_i
      |=> fr_addr_o[11:8] == 4'h0 || fr_addr_o[11:8] == 4'hF) else $error("access bank not used");
   AST_INDEXED: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == bbce_pkg::ST_FETCH && accept && !instr_i[8] && ext_mode_i && instr_i[7:0] <= 8'h5F
      |=> fr_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
      else $error("indexed offset not used");
   AST_CMP_SKIP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_cmp && fr_rdata_i == w_q |=> state_q == bbce_pkg::ST_DROP && $stable(z_q) && !fr_we_o)
      else $error("compare skip wrong");
   AST_CMP_NOFLAGS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_cmp |=> $stable(z_q) && $stable(n_q) && $stable(w_q) && !fr_we_o) else $error("compare changed state");
   AST_WATCHDOG: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_wds |=> watchdog_counter_clear_o && to_q && pd_q ##1 !watchdog_counter_clear_o)
      else $error("watchdog service wrong");
   AST_FLIP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ex && is_flip |=> fr_we_o && fr_wdata_o == ($past(fr_rdata_i) ^ $past(bit_mask)) && $stable(z_q))
      else $error("bit flip wrong");
   COV_BZ_TAKEN: cover property (@(posedge mclk_i) disable iff (!nrst_i) ex && is_bz && z_q);
   COV_INVOKE: cover property (@(posedge mclk_i) disable iff (!nrst_i) push_q);
   COV_SKIP: cover property (@(posedge mclk_i) disable iff (!nrst_i) state_q == bbce_pkg::ST_DROP && accept);
   COV_INV_W: cover property (@(posedge mclk_i) disable iff (!nrst_i) ex && is_inv && ir_q[9]);
endmodule

// ---- logic/bbce_pkg.sv ----
// Constants for the branch, invoke, bit-flip and compare execute block
package bbce_pkg;
   // ------------------------------------------------------------
   // Opcode fields
   // ------------------------------------------------------------
   localparam logic [7:0] OP_BRANCH_ON_ZERO_SET = 8'hE0;
   localparam logic [6:0] OP_INVOKE_FIRST = 7'h76;
   localparam logic [3:0] OP_INVOKE_SECOND = 4'hF;
   localparam logic [3:0] OP_BIT_FLIP = 4'h7;
   localparam logic [15:0] OP_WATCHDOG_SERVICE = 16'h0004;
   localparam logic [5:0] OP_INVERT_FILE_BYTE = 6'h07;
   localparam logic [6:0] OP_COMPARE_EQUAL_SKIP = 7'h31;
   // ------------------------------------------------------------
   // Addressing
   // ------------------------------------------------------------
   localparam logic [7:0] INDEX_MAX = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // ------------------------------------------------------------
   // Reset values and steps
   // ------------------------------------------------------------
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] BIT_ONE = 8'h01;

   typedef enum logic [2:0] {
      ST_FETCH,
      ST_EXEC,
      ST_INVOKE2,
      ST_NOP,
      ST_DROP
   } bbce_state_t;
endpackage

// ---- verification/bbce_mem_model.sv ----
// Program memory and data register file model facing the execute block
`timescale 1ns/100ps
module bbce_mem_model (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ready_i,
   input wire logic [11:0] addr_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   output logic [15:0] word_o,
   output logic valid_o,
   output logic [7:0] rdata_o
);
   logic [7:0] regs [0:4095];
   logic [15:0] prog [0:15];
   int n_words;
   int ptr;
   int cyc;
   int take_cyc [0:15];

   initial begin
      word_o = 16'h0000;
      valid_o = 1'b0;
      rdata_o = 8'h00;
      n_words = 0;
      ptr = 0;
      cyc = 0;
   end

   // ------------------------------------------------------------
   // Word handover and register writes
   // ------------------------------------------------------------
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (nrst_i && valid_o && ready_i) begin
         take_cyc[ptr] = cyc;
         ptr = ptr + 1;
      end
      if (we_i) begin
         regs[addr_i] <= wdata_i;
      end
   end

   // Idle bus shows inverted word, never a stale copy
   always @(negedge mclk_i) begin
      rdata_o <= regs[addr_i];
      if (ptr < n_words) begin
         word_o <= prog[ptr];
         valid_o <= 1'b1;
      end else begin
         if (valid_o) begin
            word_o <= ~word_o;
         end
         valid_o <= 1'b0;
      end
   end
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the execute block
`timescale 1ns/100ps
module tb;
   logic mclk_i, nrst_i, ext_mode_i, instr_valid_i, instr_ready_o, fr_we_o;
   logic zero_flag_o, neg_flag_o, watchdog_expiry_flag_o, power_down_flag_o;
   logic watchdog_counter_clear_o, stack_push_o;
   logic [15:0] instr_i;
   logic [3:0] bank_select_pointer_i, bank_pointer_shadow_o;
   logic [11:0] index_base_i, fr_addr_o;
   logic [7:0] fr_rdata_i, fr_wdata_o, w_o, accum_shadow_o;
   logic [20:0] pc_o, stack_top_entry_o;
   logic [1:0] flags_shadow_o;
   int n_errors = 0;
   int total_checks = 0;
   int n_push, n_clr;

   bbce_exec dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .ext_mode_i(ext_mode_i), .bank_select_pointer_i(bank_select_pointer_i), .index_base_i(index_base_i),
      .fr_rdata_i(fr_rdata_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o), .fr_addr_o(fr_addr_o),
      .fr_we_o(fr_we_o), .fr_wdata_o(fr_wdata_o), .w_o(w_o), .zero_flag_o(zero_flag_o),
      .neg_flag_o(neg_flag_o), .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
      .power_down_flag_o(power_down_flag_o), .watchdog_counter_clear_o(watchdog_counter_clear_o),
      .stack_push_o(stack_push_o), .stack_top_entry_o(stack_top_entry_o), .accum_shadow_o(accum_shadow_o),
      .flags_shadow_o(flags_shadow_o), .bank_pointer_shadow_o(bank_pointer_shadow_o));
   bbce_mem_model m (.mclk_i(mclk_i), .nrst_i(nrst_i), .ready_i(instr_ready_o), .addr_i(fr_addr_o),
      .we_i(fr_we_o), .wdata_i(fr_wdata_o), .word_o(instr_i), .valid_o(instr_valid_i), .rdata_o(fr_rdata_i));

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   initial begin
      nrst_i = 1'b0;
      ext_mode_i = 1'b0;
      bank_select_pointer_i = 4'h0;
      index_base_i = 12'h000;
   end
   always @(posedge mclk_i) begin
      n_push <= n_push + int'(stack_push_o);
      n_clr <= n_clr + int'(watchdog_counter_clear_o);
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Reset, then feed n words and let the last one settle
   task automatic run(input int n);
      int t;
      @(negedge mclk_i);
      nrst_i = 1'b0;
      m.ptr = 0;
      m.n_words = n;
      repeat (2) @(negedge mclk_i);
      n_push = 0;
      n_clr = 0;
      nrst_i = 1'b1;
      t = 0;
      while (m.ptr < n && t < 200) begin
         @(negedge mclk_i);
         t++;
      end
      repeat (4) @(negedge mclk_i);
      chk("words_taken", n, m.ptr);
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_invert;
      logic [11:0] ea [5];
      logic [7:0] fa [5];
      ea = '{12'h510, 12'h020, 12'hF80, 12'h35F, 12'hF60};
      fa = '{8'h10, 8'h20, 8'h80, 8'h5F, 8'h60};
      bank_select_pointer_i = 4'h5;
      index_base_i = 12'h300;
      for (int i = 0; i < 5; i++) begin
         ext_mode_i = (i > 2);
         m.regs[ea[i]] = 8'h7F;
         m.prog[0] = {7'h0E, i == 0, fa[i]};
         run(1);
         chk("inv_file", 8'h80, m.regs[ea[i]]);
         chk("inv_flags", 2'h2, {neg_flag_o, zero_flag_o});
      end
      ext_mode_i = 1'b0;
   endtask

   task automatic t_branch;
      m.prog[0] = 16'hE0FD;
      m.prog[1] = 16'h0000;
      run(2);
      chk("bz_idle_pc", 21'h000004, pc_o);
      chk("bz_idle_gap", 2, m.take_cyc[1] - m.take_cyc[0]);
      m.regs[12'h040] = 8'hFF;
      m.prog[0] = 16'h1E40;
      m.prog[1] = 16'hE0FD;
      m.prog[2] = 16'h0000;
      run(3);
      chk("bz_pc", 21'h000000, pc_o);
      chk("bz_gap", 3, m.take_cyc[2] - m.take_cyc[1]);
      chk("inv_w", 8'h00, w_o);
      chk("inv_keep", 8'hFF, m.regs[12'h040]);
      chk("inv_zero", 2'h1, {neg_flag_o, zero_flag_o});
   endtask

   task automatic t_invoke;
      bank_select_pointer_i = 4'hA;
      m.regs[12'h040] = 8'h01;
      m.prog[0] = 16'h1E40;
      m.prog[1] = 16'hEDDE;
      m.prog[2] = 16'hFABC;
      run(3);
      chk("call_pc", 21'h1579BC, pc_o);
      chk("call_gap", 1, m.take_cyc[2] - m.take_cyc[1]);
      chk("call_tos", 21'h000006, stack_top_entry_o);
      chk("call_push", 1, n_push);
      chk("call_shadows", 14'h3FAA, {accum_shadow_o, flags_shadow_o, bank_pointer_shadow_o});
      m.prog[1] = 16'hECDE;
      run(3);
      chk("call_noshadow", 14'h0000, {accum_shadow_o, flags_shadow_o, bank_pointer_shadow_o});
      chk("call_push2", 1, n_push);
   endtask

   task automatic t_compare;
      for (int i = 0; i < 2; i++) begin
         m.regs[12'h040] = 8'h25;
         m.regs[12'h041] = 8'hDA + i[7:0];
         m.regs[12'h042] = 8'h00;
         m.regs[12'h043] = 8'h0F;
         m.prog[0] = 16'h1E40;
         m.prog[1] = 16'h6241;
         m.prog[2] = 16'h1E42;
         m.prog[3] = 16'h1C43;
         run(4);
         chk("cmp_w", i == 0 ? 8'hDA : 8'hFF, w_o);
         chk("cmp_flags", 2'h2, {neg_flag_o, zero_flag_o});
         chk("cmp_nostore", 8'hDA + i[7:0], m.regs[12'h041]);
         chk("cmp_next", 8'hF0, m.regs[12'h043]);
         chk("cmp_pc", 21'h000008, pc_o);
      end
   endtask

   task automatic t_flip;
      bank_select_pointer_i = 4'h5;
      m.regs[12'h040] = 8'hFF;
      m.regs[12'h5C3] = 8'h3C;
      m.prog[0] = 16'h1E40;
      for (int b = 0; b < 8; b++) begin
         m.prog[b + 1] = {4'h7, b[2:0], 1'b1, 8'hC3};
      end
      run(9);
      chk("flip_byte", 8'hC3, m.regs[12'h5C3]);
      chk("flip_flags", 2'h1, {neg_flag_o, zero_flag_o});
   endtask

   task automatic t_wdog;
      m.prog[0] = 16'h0004;
      run(1);
      chk("wdt_clear", 1, n_clr);
      chk("wdt_flags", 2'h3, {watchdog_expiry_flag_o, power_down_flag_o});
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      t_invert();
      t_branch();
      t_invoke();
      t_compare();
      t_flip();
      t_wdog();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_errors++;
      $display("mismatch watchdog expected finish seen timeout");
      complete_run();
   end
endmodule
